// file: include/thal_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 100 MHz clk; registers reached over a plain strobe port.
// Notes: Rules follow, one line each.
// Summary of operation
// - Temperature stored as 16-bit two's complement word
// - Value in bits 15..7, bits 6..0 zero
// - Reads never disturb conversion in progress
// - Compare each result against both limits
// - Polarity bit selects alert level, default low
// - Comparator: assert after N consecutive highs
// - Comparator: deassert after N consecutive lows
// - Comparator: shutdown keeps alert unchanged
// - Interrupt: first assert on N highs
// - Interrupt: any read or shutdown clears
// - Interrupt: next trigger is N lows
// - Interrupt: alert holds until read/shutdown
// - Fault queue field selects 1,2,4,6
// - Assert one period later if fault remains
// - Shutdown finishes and stores current conversion
// - Bus works in shutdown; zero resumes
// - Values are 9-bit half-degree two's complement
// - Bus timeout on SDA low resets interface
// - Defaults run standalone thermostat
// - Limit registers hold any written value
// - Mode bit: 0 comparator, 1 interrupt
// - Limits default to 80 and 75 degrees
// - Compare only nine MSBs of limits
`ifndef THAL_DEFINES_SVH
`define THAL_DEFINES_SVH
`define THAL_REG_TEMP 2'h0
`define THAL_REG_CONF 2'h1
`define THAL_REG_LOW 2'h2
`define THAL_REG_HIGH 2'h3
`define THAL_CONF_SD 0
`define THAL_CONF_MODE 1
`define THAL_CONF_POL 2
`define THAL_CONF_FQ_LO 3
`define THAL_CONF_FQ_HI 4
`define THAL_CONF_RESET 8'h00
`define THAL_CONF_WMASK 8'h1F
`define THAL_HIGH_RESET 16'h5000
`define THAL_LOW_RESET 16'h4B00
`define THAL_TEMP_RESET 16'h0000
`define THAL_CONV_MS 150
`define THAL_CLK_MHZ 100
`define THAL_CONV_CYCLES (`THAL_CONV_MS * `THAL_CLK_MHZ * 1000)
`define THAL_TIMEOUT_MS 25
`define THAL_TIMEOUT_CYCLES (`THAL_TIMEOUT_MS * `THAL_CLK_MHZ * 1000)
`endif

// file: include/thal_pkg.sv
// Purpose: Types shared by the thermal alarm logic.
// Assumes: Nothing beyond the defines header.
// Notes: Bus request travels as one packed struct.
package thal_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [15:0] wdata;
    } thal_req_t;
    typedef enum logic [2:0] {
        THAL_BUS_IDLE = 3'h1,
        THAL_BUS_ACTIVE = 3'h2,
        THAL_BUS_TIMEOUT = 3'h4
    } thal_bus_state_t;
endpackage

// file: hw/thal_fault_queue.sv
// Purpose: Counts an unbroken run of qualifying measurements.
// Assumes: One evaluation pulse per conversion.
// Notes: Reports satisfied once the run reaches the target length.
`timescale 1ns/1ps
module thal_fault_queue #(
    parameter int CW = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic eval,
    input wire logic cond,
    input wire logic clear,
    input wire logic [CW-1:0] target,
    output logic met_q
);
    logic [CW-1:0] count_q;
    if (CW < 3) begin : g_bad_width
        $error("thal_fault_queue: CW cannot hold a count of 6");
    end
    // An evaluation in the same cycle as a clear wins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
        end else if (eval) begin
            if (!cond) begin
                count_q <= '0;
            end else if (count_q < target) begin
                count_q <= count_q + 1'b1;
            end
        end else if (clear) begin
            count_q <= '0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            met_q <= 1'b0;
        end else if (eval) begin
            met_q <= cond && (count_q + 1'b1 >= target);
        end else if (clear) begin
            met_q <= 1'b0;
        end
    end
endmodule

// file: hw/thal_core.sv
// Purpose: Thermal alarm back end: formats results, limits, alert pin.
// Assumes: Converter gives a 9-bit result and a done pulse.
// Notes: Alert is open drain; oe low means pin driven low.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "thal_defines.svh"
module thal_core #(
    parameter int CONV_CYCLES = `THAL_CONV_CYCLES,
    parameter int TIMEOUT_CYCLES = `THAL_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire thal_pkg::thal_req_t req,
    output logic [15:0] rdata_q,
    input wire logic [8:0] adc_result,
    output logic conv_start_q,
    input wire logic conv_done,
    output logic alert_out_o_q,
    output logic alert_out_oe_q,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic bus_reset_q,
    output logic standby_q
);
    if (CONV_CYCLES < 2 || TIMEOUT_CYCLES < 2) begin : g_bad_counts
        $error("thal_core: counts too small");
    end

    function automatic logic [2:0] fq_len(input logic [1:0] f);
        case (f)
            2'b00: fq_len = 3'd1;
            2'b01: fq_len = 3'd2;
            2'b10: fq_len = 3'd4;
            default: fq_len = 3'd6;
        endcase
    endfunction

    logic [15:0] temp_q;
    logic [7:0] conf_q;
    logic [15:0] high_limit_q;
    logic [15:0] low_limit_q;
    logic [31:0] period_q;
    logic busy_q;
    logic alert_q;
    logic armed_low_q;
    logic sd_q;
    logic fault_queue_len_hi;
    logic fault_queue_len_lo;
    logic alert_active_level;
    logic shutdown_request;
    logic int_mode;
    logic [8:0] t9;
    logic hi_cond;
    logic lo_cond;
    logic hi_met;
    logic lo_met;
    logic eval_q;
    logic sd_enter;
    logic any_rd;

    assign fault_queue_len_hi = conf_q[`THAL_CONF_FQ_HI];
    assign fault_queue_len_lo = conf_q[`THAL_CONF_FQ_LO];
    assign alert_active_level = conf_q[`THAL_CONF_POL];
    assign shutdown_request = conf_q[`THAL_CONF_SD];
    assign int_mode = conf_q[`THAL_CONF_MODE];
    assign any_rd = req.rd;
    assign sd_enter = shutdown_request && !sd_q;

    // Registers written by the master.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conf_q <= `THAL_CONF_RESET;
            high_limit_q <= `THAL_HIGH_RESET;
            low_limit_q <= `THAL_LOW_RESET;
        end else if (req.wr) begin
            case (req.addr)
                `THAL_REG_CONF: conf_q <= req.wdata[7:0] & `THAL_CONF_WMASK;
                `THAL_REG_HIGH: high_limit_q <= req.wdata;
                `THAL_REG_LOW: low_limit_q <= req.wdata;
                default: ;
            endcase
        end
    end

    // Read port; data stand one cycle after the strobe.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            case (req.addr)
                `THAL_REG_TEMP: rdata_q <= temp_q;
                `THAL_REG_CONF: rdata_q <= {8'h00, conf_q};
                `THAL_REG_LOW: rdata_q <= low_limit_q;
                default: rdata_q <= high_limit_q;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // Conversion pacing; shutdown lets the running conversion finish.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            period_q <= '0;
            busy_q <= 1'b0;
            conv_start_q <= 1'b0;
            standby_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            if (busy_q) begin
                if (conv_done) begin
                    busy_q <= 1'b0;
                end
            end else if (shutdown_request) begin
                standby_q <= 1'b1;
            end else begin
                standby_q <= 1'b0;
            end
            if (period_q != 32'h0000_0000) begin
                period_q <= period_q - 32'h0000_0001;
            end else if (!busy_q && !shutdown_request) begin
                period_q <= 32'(CONV_CYCLES - 1);
                busy_q <= 1'b1;
                conv_start_q <= 1'b1;
            end
        end
    end

    // Result store in the 9 upper bits; the lower bits read as zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_q <= `THAL_TEMP_RESET;
            eval_q <= 1'b0;
        end else begin
            eval_q <= busy_q && conv_done;
            if (busy_q && conv_done) begin
                temp_q <= {adc_result, 7'h00};
            end
        end
    end

    assign t9 = temp_q[15:7];
    assign hi_cond = $signed(t9) > $signed(high_limit_q[15:7]);
    assign lo_cond = $signed(t9) < $signed(low_limit_q[15:7]);

    thal_fault_queue #(.CW(3)) u_hi_queue (
        .clk(clk),
        .resetn(resetn),
        .eval(eval_q),
        .cond(hi_cond),
        .clear(sd_enter),
        .target(fq_len({fault_queue_len_hi, fault_queue_len_lo})),
        .met_q(hi_met)
    );
    thal_fault_queue #(.CW(3)) u_lo_queue (
        .clk(clk),
        .resetn(resetn),
        .eval(eval_q),
        .cond(lo_cond),
        .clear(sd_enter),
        .target(fq_len({fault_queue_len_hi, fault_queue_len_lo})),
        .met_q(lo_met)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sd_q <= 1'b0;
        end else begin
            sd_q <= shutdown_request;
        end
    end

    // Alert state; met flags still hold the previous evaluation here,
    // so the alert follows one period after the count is met.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_q <= 1'b0;
            armed_low_q <= 1'b0;
        end else if (!int_mode) begin
            armed_low_q <= 1'b0;
            if (eval_q && hi_met && hi_cond) begin
                alert_q <= 1'b1;
            end else if (eval_q && lo_met && lo_cond) begin
                alert_q <= 1'b0;
            end
            // Shutdown leaves alert_q as is here.
        end else begin
            if (eval_q && !alert_q && !armed_low_q && hi_met && hi_cond) begin
                alert_q <= 1'b1;
            end else if (eval_q && !alert_q && armed_low_q && lo_met
                    && lo_cond) begin
                alert_q <= 1'b1;
            end else if (alert_q && (any_rd || sd_enter)) begin
                alert_q <= 1'b0;
                armed_low_q <= !armed_low_q;
            end
        end
    end

    // Open-drain pin: oe low drives the pin low.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_out_o_q <= 1'b0;
            alert_out_oe_q <= 1'b1;
        end else begin
            alert_out_o_q <= 1'b0;
            alert_out_oe_q <= !(alert_q ^ alert_active_level);
        end
    end

    // Bus timeout watchdog on the synchronised link pins.
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic sda_prev_q;
    logic scl_prev_q;
    logic [31:0] to_cnt_q;
    thal_pkg::thal_bus_state_t bus_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            sda_prev_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            sda_prev_q <= sda_s_q[1];
            scl_prev_q <= scl_s_q[1];
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_q <= thal_pkg::THAL_BUS_IDLE;
            to_cnt_q <= '0;
            bus_reset_q <= 1'b0;
        end else begin
            bus_reset_q <= 1'b0;
            case (bus_q)
                thal_pkg::THAL_BUS_IDLE: begin
                    to_cnt_q <= '0;
                    if (scl_s_q[1] && scl_prev_q && sda_prev_q
                            && !sda_s_q[1]) begin
                        bus_q <= thal_pkg::THAL_BUS_ACTIVE;
                    end
                end
                thal_pkg::THAL_BUS_ACTIVE: begin
                    if (scl_s_q[1] && !sda_prev_q && sda_s_q[1]) begin
                        bus_q <= thal_pkg::THAL_BUS_IDLE;
                    end else if (sda_s_q[1]) begin
                        to_cnt_q <= '0;
                    end else if (to_cnt_q >= 32'(TIMEOUT_CYCLES - 1)) begin
                        bus_reset_q <= 1'b1;
                        bus_q <= thal_pkg::THAL_BUS_TIMEOUT;
                    end else begin
                        to_cnt_q <= to_cnt_q + 32'h0000_0001;
                    end
                end
                thal_pkg::THAL_BUS_TIMEOUT: begin
                    to_cnt_q <= '0;
                    if (sda_s_q[1]) begin
                        bus_q <= thal_pkg::THAL_BUS_IDLE;
                    end
                end
                default: bus_q <= thal_pkg::THAL_BUS_IDLE;
            endcase
        end
    end
endmodule

// file: verif/thal_core_assertions.sv
// Purpose: Concurrent checks on the thermal alarm core ports.
// Assumes: The configuration byte is shadowed from bus writes.
// Notes: Bound to every instance of the core.
`timescale 1ns/1ps
module thal_core_chk #(
    parameter int CONV_CYCLES = 50,
    parameter int TIMEOUT_CYCLES = 40
) (
    input wire logic clk,
    input wire logic resetn,
    input wire thal_pkg::thal_req_t req,
    input wire logic [15:0] rdata_q,
    input wire logic [8:0] adc_result,
    input wire logic conv_start_q,
    input wire logic conv_done,
    input wire logic alert_out_o_q,
    input wire logic alert_out_oe_q,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic bus_reset_q,
    input wire logic standby_q
);
    logic [7:0] conf_q;
    logic [3:0] since_done_q;
    int sda_low_q;
    logic conv_busy_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conf_q <= 8'h00;
        end else if (req.wr && req.addr == 2'h1) begin
            conf_q <= req.wdata[7:0] & 8'h1F;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            since_done_q <= 4'hF;
        end else if (conv_done) begin
            since_done_q <= 4'h0;
        end else if (since_done_q != 4'hF) begin
            since_done_q <= since_done_q + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_low_q <= 0;
        end else begin
            sda_low_q <= sda_i ? 0 : sda_low_q + 1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_busy_q <= 1'b0;
        end else if (conv_start_q) begin
            conv_busy_q <= 1'b1;
        end else if (conv_done) begin
            conv_busy_q <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_open_drain: assert property (alert_out_o_q == 1'b0)
        else $error("alert data line not low");
    a_temp_pad_zero: assert property ($past(req.rd) &&
        $past(req.addr) == 2'h0 |-> rdata_q[6:0] == 7'h00)
        else $error("temperature pad bits not zero");
    a_conf_readback: assert property ($past(req.rd) &&
        $past(req.addr) == 2'h1 |-> rdata_q == {8'h00, $past(conf_q)})
        else $error("configuration readback wrong");
    a_read_clears: assert property (conf_q[1] && req.rd &&
        since_done_q == 4'hF |-> ##2 alert_out_oe_q == !conf_q[2])
        else $error("read did not clear alert");
    a_alert_cause: assert property ($changed(alert_out_oe_q) |->
        since_done_q inside {[4'h2:4'h6]} || $past(req.rd, 2) ||
        $past(req.wr) || $past(req.wr, 2) || $past(req.wr, 3))
        else $error("alert moved without cause");
    a_start_pulse: assert property (conv_start_q |=> !conv_start_q)
        else $error("conversion start longer than a pulse");
    a_quiet_standby: assert property (standby_q |-> !conv_start_q)
        else $error("conversion started in standby");
    a_standby_entry: assert property ($rose(standby_q) |->
        conf_q[0] && !conv_busy_q)
        else $error("standby entered out of turn");
    a_wake_up: assert property ($fell(conf_q[0]) |->
        ##[0:8] !standby_q)
        else $error("standby not left");
    a_timeout_len: assert property (bus_reset_q |->
        sda_low_q > TIMEOUT_CYCLES)
        else $error("bus reset too early");
    a_reset_pulse: assert property (bus_reset_q |=> !bus_reset_q)
        else $error("bus reset longer than a pulse");
    cover property (!alert_out_oe_q && !conf_q[2]);
    cover property ($rose(standby_q));
    cover property (bus_reset_q);
endmodule
bind thal_core thal_core_chk #(.CONV_CYCLES(CONV_CYCLES),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clk(clk), .resetn(resetn),
    .req(req), .rdata_q(rdata_q), .adc_result(adc_result),
    .conv_start_q(conv_start_q), .conv_done(conv_done),
    .alert_out_o_q(alert_out_o_q), .alert_out_oe_q(alert_out_oe_q),
    .scl_i(scl_i), .sda_i(sda_i), .bus_reset_q(bus_reset_q),
    .standby_q(standby_q));

// file: verif/thal_conv_model.sv
// Purpose: Converter model that answers each start with a result.
// Assumes: One conversion at a time.
// Notes: Result lines toggle outside the done cycle.
`timescale 1ns/1ps
module thal_conv_model #(
    parameter int LAT = 20
) (
    input wire logic clk,
    input wire logic conv_start,
    input wire logic [8:0] temp,
    output logic conv_done,
    output logic [8:0] adc_result
);
    int cnt = 0;
    initial conv_done = 1'b0;
    initial adc_result = 9'h000;
    always @(posedge clk) begin
        conv_done <= (cnt == 1);
        adc_result <= (cnt == 1) ? temp : ~adc_result;
        if (conv_start) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: verif/tb_thermal_alarm_logic.sv
// Purpose: Self-checking bench for the thermal alarm core.
// Assumes: Short conversion and timeout counts.
// Notes: A converter model supplies the results.
`timescale 1ns/1ps
module tb_thermal_alarm_logic;
    localparam logic [8:0] HOT = 9'h0A2;
    localparam logic [8:0] COLD = 9'h090;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl_i = 1'b1;
    logic sda_i = 1'b1;
    logic [8:0] temp = 9'h000;
    thal_pkg::thal_req_t req = '0;
    logic [15:0] rdata_q;
    logic [8:0] adc_result;
    logic conv_start_q, conv_done, alert_out_o_q, alert_out_oe_q;
    logic bus_reset_q, standby_q;
    int errors = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    thal_core #(.CONV_CYCLES(50), .TIMEOUT_CYCLES(40)) dut (.clk(clk),
        .resetn(resetn), .req(req), .rdata_q(rdata_q),
        .adc_result(adc_result), .conv_start_q(conv_start_q),
        .conv_done(conv_done), .alert_out_o_q(alert_out_o_q),
        .alert_out_oe_q(alert_out_oe_q), .scl_i(scl_i), .sda_i(sda_i),
        .bus_reset_q(bus_reset_q), .standby_q(standby_q));
    thal_conv_model conv_m (.clk(clk), .conv_start(conv_start_q),
        .temp(temp), .conv_done(conv_done), .adc_result(adc_result));
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [15:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rd(logic [1:0] a, logic [15:0] exp);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        req <= '0;
        #1 chk("rdata", exp, rdata_q);
        @(posedge clk);
    endtask
    task automatic al(logic e);
        #1 chk("alert_oe", {15'h0000, e}, {15'h0000, alert_out_oe_q});
        @(posedge clk);
    endtask
    task automatic conv(int k);
        repeat (k) begin
            do @(posedge clk); while (conv_done !== 1'b1);
        end
        repeat (6) @(posedge clk);
    endtask
    task automatic sleep();
        do @(posedge clk); while (standby_q !== 1'b1);
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset();
        rd(2'h3, 16'h5000);
        rd(2'h2, 16'h4B00);
        rd(2'h1, 16'h0000);
        rd(2'h0, 16'h0000);
        al(1'b1);
    endtask
    task automatic t_format();
        temp <= 9'h1CE;
        conv(1);
        rd(2'h0, 16'hE700);
        wr(2'h0, 16'h1234);
        rd(2'h0, 16'hE700);
        temp <= 9'h0FA;
        conv(1);
        rd(2'h0, 16'h7D00);
        temp <= COLD;
        conv(3);
    endtask
    task automatic t_queue();
        int n;
        for (int c = 0; c < 4; c++) begin
            n = (c == 3) ? 6 : (1 << c);
            wr(2'h1, {11'h000, c[1:0], 3'h0});
            temp <= HOT;
            conv(n - 1);
            temp <= COLD;
            conv(1);
            temp <= HOT;
            conv(n);
            al(1'b1);
            conv(1);
            al(1'b0);
            temp <= COLD;
            conv(n + 1);
            al(1'b1);
        end
    endtask
    task automatic t_int();
        wr(2'h1, 16'h0002);
        conv(3);
        al(1'b1);
        temp <= HOT;
        conv(2);
        al(1'b0);
        conv(3);
        al(1'b0);
        repeat (10) @(posedge clk);
        rd(2'h2, 16'h4B00);
        al(1'b1);
        conv(3);
        al(1'b1);
        temp <= COLD;
        conv(2);
        al(1'b0);
        rd(2'h1, 16'h0002);
        al(1'b1);
    endtask
    task automatic t_sd();
        wr(2'h1, 16'h0004);
        repeat (4) @(posedge clk);
        al(1'b0);
        temp <= HOT;
        conv(2);
        al(1'b1);
        temp <= 9'h0A4;
        do @(posedge clk); while (conv_start_q !== 1'b1);
        wr(2'h1, 16'h0005);
        sleep();
        al(1'b1);
        rd(2'h0, 16'h5200);
        wr(2'h1, 16'h0002);
        conv(2);
        al(1'b0);
        wr(2'h1, 16'h0003);
        sleep();
        al(1'b1);
        wr(2'h1, 16'h0000);
        conv(1);
        chk("standby", 16'h0000, {15'h0000, standby_q});
    endtask
    task automatic t_regs();
        wr(2'h3, 16'hA57F);
        rd(2'h3, 16'hA57F);
        wr(2'h2, 16'h8001);
        rd(2'h2, 16'h8001);
        wr(2'h1, 16'h00FE);
        rd(2'h1, 16'h001E);
        wr(2'h1, 16'h0000);
    endtask
    task automatic t_timeout();
        int n;
        n = 0;
        sda_i <= 1'b0;
        while (bus_reset_q !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
            if (n % 8 == 0) scl_i <= ~scl_i;
        end
        chk("timeout", 16'h0001, {15'h0000, n > 40 && n <= 50});
        scl_i <= 1'b1;
        repeat (8) @(posedge clk);
        sda_i <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic results();
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_format();
        t_queue();
        t_int();
        t_sd();
        t_regs();
        t_timeout();
        results();
    end
endmodule
